// file: hdl/pmlc_pkg.sv
package pmlc_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h0C;
  localparam logic [7:0] STOPS_OFS     = 8'h10;
  // Control fields
  localparam int CTRL_TUNE_EN_BIT   = 0;
  localparam int CTRL_FLT_RESET_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Status fields
  localparam int STAT_SELFCLR_BIT = 4;
  localparam int STAT_AIR_BIT     = 5;
  localparam int STAT_TUNESEL_BIT = 6;
  localparam int STAT_PNEU_BIT    = 7;
  localparam int STOPS_UPPER_LSB  = 16;
  // Interrupt bits
  localparam int IRQ_MODE_BIT  = 0;
  localparam int IRQ_FSAFE_BIT = 1;
  localparam int IRQ_PFAIL_BIT = 2;
  localparam int IRQ_NAK_BIT   = 3;
  localparam int IRQ_W         = 4;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  // Local buttons and selector
  localparam int BTN_FIND   = 0;
  localparam int BTN_ADJ    = 1;
  localparam int BTN_TUNE   = 2;
  localparam int BTN_CANCEL = 3;
  localparam int CFG_AIR    = 0;
  localparam int CFG_TUNE   = 1;
  // Host command codes; codes from HC_SETTING_MIN up are settings
  localparam logic [3:0] HC_ENTER_OVR   = 4'h0;
  localparam logic [3:0] HC_EXIT_OVR    = 4'h1;
  localparam logic [3:0] HC_SET_POS     = 4'h2;
  localparam logic [3:0] HC_AUTOTUNE    = 4'h3;
  localparam logic [3:0] HC_SETTING_MIN = 4'h4;
  // Position range
  localparam logic [11:0] POS_CLOSED = 12'h000;
  localparam logic [11:0] POS_OPEN   = 12'hFFF;
  // Timing
  localparam int CLK_MHZ   = 20;
  localparam int SETTLE_US = 2000;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int STEP_MS   = 250;
  localparam int STEP_CYC  = STEP_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    PMLC_NORMAL, PMLC_OVERRIDE, PMLC_FAILSAFE, PMLC_FIND, PMLC_ADJ, PMLC_TUNE, PMLC_PFAIL
  } pmlc_mode_e;

  typedef enum logic [3:0] {
    IND_NORMAL, IND_ALERT, IND_OVERRIDE, IND_FAILSAFE, IND_FIND, IND_ADJ, IND_TUNE,
    IND_FAIL_FIND, IND_FAIL_ADJ, IND_FAIL_TUNE
  } pmlc_ind_e;
endpackage : pmlc_pkg

// file: hdl/pmlc_led_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pmlc_led_if;
  import pmlc_pkg::*;
  pmlc_ind_e  cond;
  logic [2:0] oor;
  logic       lowPower;
  logic [3:0] leds;
  modport ctl (output cond, output oor, output lowPower, input leds);
  modport gen (input cond, input oor, input lowPower, output leds);
endinterface : pmlc_led_if
`default_nettype wire

// file: hdl/pmlc_led_gen.sv
`timescale 1ns/1ps
`default_nettype none
module pmlc_led_gen #(
  parameter int STEP = pmlc_pkg::STEP_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Indicator link
  pmlc_led_if.gen  lk
);
  import pmlc_pkg::*;

  // Patterns: LED4 (bit 3) is red, LED1..3 green; 8 steps, step 0 in bits [3:0]
  function automatic logic [31:0] patternOf(input pmlc_ind_e c);
    unique case (c)
      IND_NORMAL:    patternOf = 32'h0000_0004;
      IND_ALERT:     patternOf = 32'h0000_8888;
      IND_OVERRIDE:  patternOf = 32'h0000_0808;
      IND_FAILSAFE:  patternOf = 32'h8888_8888;
      IND_FIND:      patternOf = 32'h0000_4210;
      IND_ADJ:       patternOf = 32'h0000_2020;
      IND_TUNE:      patternOf = 32'h0000_0707;
      IND_FAIL_FIND: patternOf = 32'h0000_9191;
      IND_FAIL_ADJ:  patternOf = 32'h0000_A2A2;
      IND_FAIL_TUNE: patternOf = 32'h0000_C4C4;
      default:       patternOf = 32'h0000_0000;
    endcase
  endfunction : patternOf

  logic [22:0] tick;
  logic [2:0]  step;
  logic        fastPhase;
  pmlc_ind_e   condPrev;

  wire         condChange = (lk.cond != condPrev);
  wire         halfDone   = (tick == 23'(STEP / 2 - 1));
  wire         stepDone   = (tick == 23'(STEP - 1));
  wire [31:0]  pat        = patternOf(lk.cond);
  wire [3:0]   patLeds    = pat[{step, 2'b00} +: 4];
  logic [3:0]  next_leds;

  // Fast blink toggles twice per step: double the normal rate
  always_comb begin
    next_leds = patLeds;
    for (int i = 0; i < 3; i++) begin
      if (lk.oor[i]) begin
        next_leds[i] = fastPhase;
      end
    end
    if (lk.lowPower) begin
      next_leds = 4'h0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick      <= '0;
      step      <= '0;
      fastPhase <= 1'b0;
      condPrev  <= IND_NORMAL;
      lk.leds   <= 4'h0;
    end else begin
      condPrev <= lk.cond;
      // A new condition restarts its pattern from the first step
      tick      <= (condChange || stepDone) ? '0 : tick + 23'h1;
      step      <= condChange ? 3'h0 : (stepDone ? step + 3'h1 : step);
      fastPhase <= (halfDone || stepDone) ? ~fastPhase : fastPhase;
      lk.leds   <= next_leds;
    end
  end

  property p_dark;
    @(posedge mclk) disable iff (rst) lk.lowPower |=> (lk.leds == 4'h0);
  endproperty
  a_dark: assert property (p_dark) else $error("LEDs lit in low power");

  property p_redSolid;
    @(posedge mclk) disable iff (rst)
      (lk.cond == IND_FAILSAFE && !lk.lowPower) [*2] |-> lk.leds[3];
  endproperty
  a_redSolid: assert property (p_redSolid) else $error("Red LED not steady in failsafe");
endmodule : pmlc_led_gen
`default_nettype wire

// file: hdl/pmlc_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pmlc_mode_ctrl #(
  parameter int SETTLE = pmlc_pkg::SETTLE_CYC,
  parameter int STEP   = pmlc_pkg::STEP_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // Local pins
  input  wire logic [3:0]  localBtn,
  input  wire logic [1:0]  cfgSwitch,
  // Mode retention store
  input  wire logic [2:0]  nvMode,
  input  wire logic        nvValid,
  output logic [2:0]       storedMode,
  // Supervision inputs
  input  wire logic        faultActive,
  input  wire logic        faultSelfClear,
  input  wire logic        deviceAlert,
  input  wire logic        lowPower,
  input  wire logic [2:0]  settingOor,
  // Position loop
  input  wire logic [11:0] setpoint,
  input  wire logic [11:0] posFeedback,
  input  wire logic [11:0] adjPot,
  input  wire logic        tuneDone,
  input  wire logic        tuneFail,
  output logic [11:0]      positionCmd,
  output logic             pneuLow,
  output logic             airAction,
  output logic             tuneStart,
  // Host commands
  input  wire logic        hostValid,
  input  wire logic [3:0]  hostCode,
  input  wire logic [11:0] hostData,
  output logic             hostAck,
  output logic             hostNak,
  output logic             hostExec,
  output logic [3:0]       hostExecCode,
  // Status LEDs
  output logic [3:0]       ledOut
);
  import pmlc_pkg::*;

  // Pin synchronisers: three stages, a change counts once stages 2 and 3 agree
  logic [5:0] sync1, sync2, sync3, pinStable, pinPrev;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1     <= '0;
      sync2     <= '0;
      sync3     <= '0;
      pinStable <= '0;
      pinPrev   <= '0;
    end else begin
      sync1     <= {cfgSwitch, localBtn};
      sync2     <= sync1;
      sync3     <= sync2;
      pinStable <= (sync2 & sync3) | (pinStable & (sync2 | sync3));
      pinPrev   <= pinStable;
    end
  end
  wire [3:0] press    = pinStable[3:0] & ~pinPrev[3:0];
  wire       anyPress = |press;
  wire       cfgTune  = pinStable[4 + CFG_TUNE];
  wire       cfgAir   = pinStable[4 + CFG_AIR];

  // Registers
  pmlc_mode_e  mode, next_mode;
  logic        booted, selfClrLatch, findHigh, tuneEn, faultReset;
  logic [1:0]  failedProc;
  logic [15:0] settle;
  logic [11:0] lowerStop, upperStop, hostPos;
  logic [3:0]  irqStat, irqMask;

  wire setupPh  = psel && !penable;
  wire accessPh = psel && penable;
  wire selCtrl  = (paddr == CTRL_OFS);
  wire selStat  = (paddr == STATUS_OFS);
  wire selIrqS  = (paddr == IRQ_STAT_OFS);
  wire selIrqM  = (paddr == IRQ_MASK_OFS);
  wire selStops = (paddr == STOPS_OFS);
  wire mapped   = selCtrl | selStat | selIrqS | selIrqM | selStops;
  wire wrCtrl   = accessPh && pwrite && selCtrl;
  wire wrMask   = accessPh && pwrite && selIrqM;
  wire rdIrqClr = accessPh && !pwrite && selIrqS;

  // Host command decode
  wire isSetting = (hostCode >= HC_SETTING_MIN) || (hostCode == HC_SET_POS);
  wire inOvr     = (mode == PMLC_OVERRIDE);
  wire hostOk    = hostValid && (
                   (hostCode == HC_ENTER_OVR && mode == PMLC_NORMAL) ||
                   (hostCode == HC_EXIT_OVR && inOvr) ||
                   (hostCode == HC_AUTOTUNE && inOvr && tuneEn && cfgTune) ||
                   (isSetting && inOvr));
  wire hostEnter = hostOk && !faultActive && (hostCode == HC_ENTER_OVR);
  wire hostExit  = hostOk && (hostCode == HC_EXIT_OVR);

  // Stop finding: settle at closed, take lower; settle at open, take upper
  wire settleDone = (settle == 16'(SETTLE - 1));
  wire findLowEnd = (mode == PMLC_FIND) && !findHigh && settleDone;
  wire findEnd    = (mode == PMLC_FIND) && findHigh && settleDone;
  wire findGood   = posFeedback > lowerStop;

  // A latched fault cannot be cleared while it is still present
  wire fsClear = !faultActive && (selfClrLatch || faultReset);

  // Resume mode: failsafe is not resumed once its cause is gone, processes never are
  pmlc_mode_e resumeMode;
  always_comb begin
    resumeMode = PMLC_NORMAL;
    if (nvValid && nvMode == 3'(PMLC_OVERRIDE)) begin
      resumeMode = PMLC_OVERRIDE;
    end else if (nvValid && nvMode == 3'(PMLC_FAILSAFE) && faultActive) begin
      resumeMode = PMLC_FAILSAFE;
    end
  end

  always_comb begin
    next_mode = mode;
    if (!booted) begin
      next_mode = resumeMode;
    end else if (faultActive && mode != PMLC_FAILSAFE) begin
      next_mode = PMLC_FAILSAFE;
    end else begin
      unique case (mode)
        PMLC_NORMAL: begin
          if (hostEnter) begin
            next_mode = PMLC_OVERRIDE;
          end else if (press[BTN_FIND]) begin
            next_mode = PMLC_FIND;
          end else if (press[BTN_ADJ]) begin
            next_mode = PMLC_ADJ;
          end else if (press[BTN_TUNE] && cfgTune) begin
            next_mode = PMLC_TUNE;
          end
        end
        PMLC_OVERRIDE: begin
          if (anyPress || hostExit) begin
            next_mode = PMLC_NORMAL;
          end
        end
        PMLC_FAILSAFE: begin
          if (fsClear) begin
            next_mode = PMLC_NORMAL;
          end
        end
        PMLC_FIND: begin
          if (press[BTN_CANCEL]) begin
            next_mode = PMLC_NORMAL;
          end else if (findEnd) begin
            next_mode = findGood ? PMLC_NORMAL : PMLC_PFAIL;
          end
        end
        PMLC_ADJ: begin
          if (press[BTN_CANCEL] || press[BTN_ADJ]) begin
            next_mode = PMLC_NORMAL;
          end
        end
        PMLC_TUNE: begin
          if (tuneFail) begin
            next_mode = PMLC_PFAIL;
          end else if (tuneDone || press[BTN_CANCEL]) begin
            next_mode = PMLC_NORMAL;
          end
        end
        PMLC_PFAIL: begin
          if (press[BTN_CANCEL]) begin
            next_mode = PMLC_NORMAL;
          end
        end
        default: next_mode = PMLC_FAILSAFE;
      endcase
    end
  end

  // Position command follows the mode it is computed for
  logic [11:0] next_pos;
  always_comb begin
    unique case (next_mode)
      PMLC_FAILSAFE: next_pos = POS_CLOSED;
      PMLC_OVERRIDE: next_pos = hostPos;
      PMLC_FIND:     next_pos = (findHigh || findLowEnd) ? POS_OPEN : POS_CLOSED;
      PMLC_ADJ:      next_pos = adjPot;
      default:       next_pos = setpoint;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode         <= PMLC_NORMAL;
      booted       <= 1'b0;
      positionCmd  <= POS_CLOSED;
      pneuLow      <= 1'b0;
      selfClrLatch <= 1'b0;
      findHigh     <= 1'b0;
      settle       <= '0;
      failedProc   <= '0;
      tuneStart    <= 1'b0;
    end else begin
      booted      <= 1'b1;
      mode        <= next_mode;
      positionCmd <= next_pos;
      pneuLow     <= (next_mode == PMLC_FAILSAFE);
      tuneStart   <= (next_mode == PMLC_TUNE) && (mode != PMLC_TUNE);
      if (next_mode == PMLC_FAILSAFE && mode != PMLC_FAILSAFE) begin
        selfClrLatch <= faultSelfClear;
      end
      findHigh <= (mode == PMLC_FIND) && (findHigh || findLowEnd);
      settle   <= (mode != PMLC_FIND || settleDone) ? '0 : settle + 16'h1;
      if (next_mode == PMLC_PFAIL && mode != PMLC_PFAIL) begin
        failedProc <= (mode == PMLC_FIND) ? 2'h0 : 2'h2;
      end
    end
  end

  // Stops and host position
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lowerStop <= POS_CLOSED;
      upperStop <= POS_OPEN;
      hostPos   <= POS_CLOSED;
    end else begin
      if (findLowEnd) begin
        lowerStop <= posFeedback;
      end
      if (findEnd && findGood && !faultActive) begin
        upperStop <= posFeedback;
      end else if (mode == PMLC_ADJ && press[BTN_ADJ] && !faultActive) begin
        upperStop <= adjPot;
      end
      if (hostOk && hostCode == HC_SET_POS) begin
        hostPos <= hostData;
      end
    end
  end

  // Host answers, one cycle after the request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hostAck      <= 1'b0;
      hostNak      <= 1'b0;
      hostExec     <= 1'b0;
      hostExecCode <= 4'h0;
    end else begin
      hostAck      <= hostOk;
      hostNak      <= hostValid && !hostOk;
      hostExec     <= hostOk && (hostCode == HC_AUTOTUNE || hostCode >= HC_SETTING_MIN);
      hostExecCode <= hostCode;
    end
  end

  // Interrupt events; a new event wins over the read that clears
  wire [3:0] irqEvent;
  assign irqEvent[IRQ_MODE_BIT]  = booted && (next_mode != mode);
  assign irqEvent[IRQ_FSAFE_BIT] = booted && (next_mode == PMLC_FAILSAFE) && (mode != PMLC_FAILSAFE);
  assign irqEvent[IRQ_PFAIL_BIT] = (next_mode == PMLC_PFAIL) && (mode != PMLC_PFAIL);
  assign irqEvent[IRQ_NAK_BIT]   = hostValid && !hostOk;

  wire [31:0] statusWord = {24'h0, pneuLow, cfgTune, cfgAir, selfClrLatch, 1'b0, mode};
  wire [31:0] rdMux = selCtrl  ? {30'h0, 1'b0, tuneEn} :
                      selStat  ? statusWord :
                      selIrqS  ? {28'h0, irqStat} :
                      selIrqM  ? {28'h0, irqMask} :
                      selStops ? {4'h0, upperStop, 4'h0, lowerStop} : 32'h0;

  // Zero wait state: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = accessPh && !mapped;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata     <= 32'h0;
      tuneEn     <= CTRL_RESET[CTRL_TUNE_EN_BIT];
      faultReset <= CTRL_RESET[CTRL_FLT_RESET_BIT];
      irqStat    <= '0;
      irqMask    <= IRQ_MASK_RESET;
      irq        <= 1'b0;
    end else begin
      if (setupPh) begin
        prdata <= rdMux;
      end
      if (wrCtrl) begin
        tuneEn <= pwdata[CTRL_TUNE_EN_BIT];
      end
      faultReset <= wrCtrl && pwdata[CTRL_FLT_RESET_BIT];
      if (wrMask) begin
        irqMask <= pwdata[IRQ_W-1:0];
      end
      irqStat <= (rdIrqClr ? 4'h0 : irqStat) | irqEvent;
      irq     <= |(((rdIrqClr ? 4'h0 : irqStat) | irqEvent) & irqMask);
    end
  end

  assign airAction  = cfgAir;
  assign storedMode = 3'(mode);

  // Indicator condition and LED generator
  pmlc_led_if lk ();
  pmlc_ind_e ind;
  always_comb begin
    unique case (mode)
      PMLC_FAILSAFE: ind = IND_FAILSAFE;
      PMLC_OVERRIDE: ind = IND_OVERRIDE;
      PMLC_FIND:     ind = IND_FIND;
      PMLC_ADJ:      ind = IND_ADJ;
      PMLC_TUNE:     ind = IND_TUNE;
      PMLC_PFAIL:    ind = (failedProc == 2'h0) ? IND_FAIL_FIND : IND_FAIL_TUNE;
      default:       ind = deviceAlert ? IND_ALERT : IND_NORMAL;
    endcase
  end
  assign lk.cond     = ind;
  assign lk.oor      = settingOor;
  assign lk.lowPower = lowPower;
  assign ledOut      = lk.leds;

  pmlc_led_gen #(.STEP(STEP)) u_led (
    .mclk (mclk),
    .rst  (rst),
    .lk   (lk.gen)
  );

  // Checks
  property p_fsPriority;
    @(posedge mclk) disable iff (rst) booted && faultActive |=> mode == PMLC_FAILSAFE;
  endproperty
  a_fsPriority: assert property (p_fsPriority) else $error("Fault did not force failsafe");

  property p_fsOutput;
    @(posedge mclk) disable iff (rst) mode == PMLC_FAILSAFE |-> pneuLow && positionCmd == POS_CLOSED;
  endproperty
  a_fsOutput: assert property (p_fsOutput) else $error("Output not low in failsafe");

  property p_selfClear;
    @(posedge mclk) disable iff (rst)
      mode == PMLC_FAILSAFE && selfClrLatch && !faultActive |=> mode == PMLC_NORMAL;
  endproperty
  a_selfClear: assert property (p_selfClear) else $error("Self-clearing fault did not return");

  property p_latched;
    @(posedge mclk) disable iff (rst)
      mode == PMLC_FAILSAFE && !selfClrLatch && !faultReset |=> mode == PMLC_FAILSAFE;
  endproperty
  a_latched: assert property (p_latched) else $error("Latched fault left without reset");

  property p_ovrHold;
    @(posedge mclk) disable iff (rst)
      inOvr && !anyPress && !hostExit && !faultActive |=> inOvr;
  endproperty
  a_ovrHold: assert property (p_ovrHold) else $error("Override left without cause");

  property p_ovrLocal;
    @(posedge mclk) disable iff (rst) inOvr && anyPress && !faultActive |=> mode == PMLC_NORMAL;
  endproperty
  a_ovrLocal: assert property (p_ovrLocal) else $error("Press did not restore local control");

  property p_hostGate;
    @(posedge mclk) disable iff (rst)
      hostValid && hostCode >= HC_SETTING_MIN && !inOvr |=> hostNak && !hostExec;
  endproperty
  a_hostGate: assert property (p_hostGate) else $error("Setting accepted outside override");

  property p_tuneGate;
    @(posedge mclk) disable iff (rst) $rose(mode == PMLC_TUNE) |-> $past(cfgTune);
  endproperty
  a_tuneGate: assert property (p_tuneGate) else $error("Autotune entered with preset tuning");

  sequence s_findLow;
    mode == PMLC_FIND && findLowEnd;
  endsequence
  sequence s_lowTaken;
    ##1 lowerStop == $past(posFeedback) && positionCmd == POS_OPEN;
  endsequence
  property p_findStops;
    @(posedge mclk) disable iff (rst) (s_findLow and (!faultActive && !press[BTN_CANCEL])) |-> s_lowTaken;
  endproperty
  a_findStops: assert property (p_findStops) else $error("Lower stop not stored");
endmodule : pmlc_mode_ctrl
`default_nettype wire

// file: sim/pmlc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmlc_host_model (
  // Clock
  input  wire logic   mclk,
  // Host link
  input  wire logic   hostAck,
  input  wire logic   hostNak,
  input  wire logic   hostExec,
  output logic        hostValid,
  output logic [3:0]  hostCode,
  output logic [11:0] hostData,
  // Operator buttons
  output logic [3:0]  localBtn
);
  import pmlc_pkg::*;
  initial begin
    hostValid = 1'b0;
    hostCode  = 4'h0;
    hostData  = 12'h000;
    localBtn  = 4'h0;
  end
  // One-cycle request, answer taken one cycle later
  task automatic send(input logic [3:0] c, output logic a, output logic n, output logic x);
    @(posedge mclk);
    hostValid <= 1'b1;
    hostCode  <= c;
    hostData  <= 12'($urandom);
    @(posedge mclk);
    hostValid <= 1'b0;
    hostData  <= ~hostData;
    // Answer stands one cycle: take it mid-cycle, away from the edges
    @(negedge mclk);
    a = hostAck;
    n = hostNak;
    x = hostExec;
    @(posedge mclk);
  endtask : send
  // Held long enough to pass the pin synchroniser
  task automatic press(input int b);
    @(posedge mclk);
    localBtn[b] <= 1'b1;
    repeat (6) @(posedge mclk);
    localBtn[b] <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : press
endmodule : pmlc_host_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmlc_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, irq, nvValid, faultActive, faultSelfClear;
  logic        deviceAlert, lowPower, tuneDone, tuneFail, pneuLow, airAction, hostValid, hostAck, hostNak, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  localBtn, hostCode, ledOut;
  logic [2:0]  nvMode, settingOor, storedMode;
  logic        tuneStart, hostExec;
  int          tuneCnt;
  logic [1:0]  cfgSwitch;
  logic [11:0] setpoint, posFeedback, adjPot, positionCmd, hostData, loPos, hiPos;
  int          badCount, nCompared, cyc, cnt;
  pmlc_mode_ctrl #(.SETTLE(8), .STEP(16)) dut_u (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .localBtn(localBtn), .cfgSwitch(cfgSwitch), .nvMode(nvMode), .nvValid(nvValid), .storedMode(storedMode),
    .faultActive(faultActive), .faultSelfClear(faultSelfClear), .deviceAlert(deviceAlert),
    .lowPower(lowPower), .settingOor(settingOor), .setpoint(setpoint), .posFeedback(posFeedback),
    .adjPot(adjPot), .tuneDone(tuneDone), .tuneFail(tuneFail), .positionCmd(positionCmd),
    .pneuLow(pneuLow), .airAction(airAction), .tuneStart(tuneStart), .hostValid(hostValid), .hostCode(hostCode),
    .hostData(hostData), .hostAck(hostAck), .hostNak(hostNak), .hostExec(hostExec), .hostExecCode(),
    .ledOut(ledOut));
  pmlc_host_model host_u (.mclk(mclk), .hostAck(hostAck), .hostNak(hostNak), .hostExec(hostExec),
    .hostValid(hostValid),
    .hostCode(hostCode), .hostData(hostData), .localBtn(localBtn));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Valve model: sits high only while fully opened
  always @(posedge mclk) posFeedback <= (positionCmd === POS_OPEN) ? hiPos : loPos;
  // Local autotune starts, counted mid-cycle where the pulse is settled
  always @(negedge mclk) if (tuneStart === 1'b1) tuneCnt++;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      badCount++;
      endSim();
    end
  end
  task automatic endSim();
    if (badCount == 0 && nCompared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : endSim
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    nCompared++;
    if (g !== x) begin
      badCount++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, x);
  endtask : rchk
  // Polls instead of assuming a process length
  task automatic waitMode(input logic [2:0] m);
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, STATUS_OFS, 32'h0, rd, err);
      if (rd[2:0] === m) break;
    end
    chk({29'h0, rd[2:0]}, {29'h0, m});
  endtask : waitMode
  task automatic host(input logic [3:0] c, input logic ok);
    logic a;
    logic n;
    logic x;
    host_u.send(c, a, n, x);
    chk({30'h0, a, n}, ok ? 32'h2 : 32'h1);
    chk({31'h0, x}, {31'h0, ok && (c >= HC_AUTOTUNE)});
  endtask : host
  task automatic doReset();
    rst <= 1'b1;
    wt(20);
    rst <= 1'b0;
    wt(2);
  endtask : doReset
  initial begin
    void'($urandom(32'h5D4D));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {nvValid, faultActive, faultSelfClear, deviceAlert, lowPower, tuneDone, tuneFail} = '0;
    {nvMode, settingOor, cfgSwitch, setpoint, adjPot} = '0;
    rst = 1'b1;
    loPos = {1'b0, 11'($urandom)};
    hiPos = {1'b1, 11'($urandom)};
    doReset();
    rchk(CTRL_OFS, 32'h0);
    rchk(IRQ_MASK_OFS, 32'h0);
    rchk(STOPS_OFS, 32'h0FFF0000);
    apb(1'b0, 8'h20, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    waitMode(PMLC_NORMAL);
    setpoint <= 12'($urandom);
    cfgSwitch <= 2'h1;
    wt(6);
    chk({20'h0, positionCmd}, {20'h0, setpoint});
    chk({31'h0, airAction}, 32'h1);
    for (int c = 2; c < 16; c++) host(4'(c), 1'b0);
    host(HC_ENTER_OVR, 1'b1);
    waitMode(PMLC_OVERRIDE);
    host(HC_AUTOTUNE, 1'b0);
    wr(CTRL_OFS, 32'h1);
    cfgSwitch <= 2'h3;
    wt(6);
    host(HC_AUTOTUNE, 1'b1);
    cfgSwitch <= 2'h1;
    wt(6);
    host(HC_AUTOTUNE, 1'b0);
    for (int c = 4; c < 16; c++) host(4'(c), 1'b1);
    host_u.press(BTN_FIND);
    waitMode(PMLC_NORMAL);
    wr(IRQ_MASK_OFS, 32'h2);
    apb(1'b0, IRQ_STAT_OFS, 32'h0, rd, err);
    faultSelfClear <= 1'b1;
    host_u.press(BTN_FIND);
    faultActive <= 1'b1;
    wt(3);
    chk({31'h0, pneuLow}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    cnt = 0;
    for (int i = 0; i < 130; i++) begin
      @(negedge mclk);
      if (ledOut[3] === 1'b1) cnt++;
    end
    chk(cnt, 32'h82);
    apb(1'b0, IRQ_STAT_OFS, 32'h0, rd, err);
    chk({31'h0, rd[IRQ_FSAFE_BIT]}, 32'h1);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    faultActive <= 1'b0;
    waitMode(PMLC_NORMAL);
    faultSelfClear <= 1'b0;
    faultActive <= 1'b1;
    wt(3);
    faultActive <= 1'b0;
    wt(20);
    waitMode(PMLC_FAILSAFE);
    wr(CTRL_OFS, 32'h2);
    waitMode(PMLC_NORMAL);
    host_u.press(BTN_FIND);
    waitMode(PMLC_NORMAL);
    rchk(STOPS_OFS, {4'h0, hiPos, 4'h0, loPos});
    adjPot <= 12'($urandom);
    host_u.press(BTN_ADJ);
    waitMode(PMLC_ADJ);
    host_u.press(BTN_ADJ);
    waitMode(PMLC_NORMAL);
    rchk(STOPS_OFS, {4'h0, adjPot, 4'h0, loPos});
    host_u.press(BTN_TUNE);
    waitMode(PMLC_NORMAL);
    cfgSwitch <= 2'h3;
    wt(6);
    host_u.press(BTN_TUNE);
    waitMode(PMLC_TUNE);
    chk(tuneCnt, 32'h1);
    tuneFail <= 1'b1;
    wt(1);
    tuneFail <= 1'b0;
    wt(40);
    waitMode(PMLC_PFAIL);
    host_u.press(BTN_CANCEL);
    waitMode(PMLC_NORMAL);
    lowPower <= 1'b1;
    wt(3);
    chk({28'h0, ledOut}, 32'h0);
    lowPower <= 1'b0;
    settingOor <= 3'h1;
    cnt = 0;
    for (int i = 0; i < 128; i++) begin
      @(negedge mclk);
      if (ledOut[0] !== rd[0]) cnt++;
      rd[0] = ledOut[0];
    end
    chk({31'h0, cnt >= 15}, 32'h1);
    nvValid <= 1'b1;
    nvMode <= 3'h1;
    doReset();
    waitMode(PMLC_OVERRIDE);
    chk({29'h0, storedMode}, 32'h1);
    nvMode <= 3'h2;
    doReset();
    waitMode(PMLC_NORMAL);
    endSim();
  end
endmodule : tb
`default_nettype wire
